// ---- inc/dcfsf_pkg.sv ----
// constants for the dual-clock fifo with status flags
package dcfsf_pkg;
   localparam int DEPTH_WORDS   = 8192;
   localparam int DATA_WIDTH    = 18;
   localparam int CLK_PERIOD_NS = 10;
   localparam int FWL_NS        = 60;
   localparam int FWL_CYC       = (FWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT_NS         = 60;
   localparam int RT_CYC        = (RT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // fixed stages inside the pointer crossing: encode, two sync, decode
   localparam int XING_FIXED    = 4;
   localparam int FWL_EXTRA     = FWL_CYC - XING_FIXED;
   // control pin positions in the sampled pin vector
   localparam int PIN_WCLK      = 0;
   localparam int PIN_RCLK      = 1;
   localparam int PIN_WEN_N     = 2;
   localparam int PIN_REN_N     = 3;
   localparam int PIN_MRS_N     = 4;
   localparam int PIN_PRS_N     = 5;
   localparam int PIN_RT_N      = 6;
   localparam int PIN_FALL_THROUGH_MODE      = 7;
   localparam int PIN_CTL_W     = 8;
   // flag reset values
   localparam logic FULL_N_RST  = 1'b1;
   localparam logic IR_N_RST    = 1'b0;
   localparam logic EMPTY_N_RST = 1'b0;
   localparam logic OR_N_RST    = 1'b1;
   localparam logic AF_N_RST    = 1'b1;
   localparam logic AE_N_RST    = 1'b0;
   localparam logic HF_N_RST    = 1'b1;
endpackage : dcfsf_pkg

// ---- core/dcfsf_ptr_cross.sv ----
// gray-coded pointer crossing with optional extra latency
`timescale 1ns/1ps
`default_nettype none
module dcfsf_ptr_cross #(
   parameter int PW    = 14,
   parameter int EXTRA = 0
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          clr,
   input  wire logic [PW-1:0] bin_in,
   output logic      [PW-1:0] bin_out
);
   logic [PW-1:0] gray_r;
   logic [PW-1:0] sync1_r;
   logic [PW-1:0] sync2_r;
   logic [PW-1:0] late;

   function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray_to_bin

   // single-bit change per step, so a sample caught mid-move is old or new
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gray_r  <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (clr) begin
         gray_r  <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         gray_r  <= bin_in ^ (bin_in >> 1);
         sync1_r <= gray_r;
         sync2_r <= sync1_r;
      end
   end

   generate
      if (EXTRA > 0) begin : g_delay
         logic [PW-1:0] dly_r [EXTRA];
         for (genvar k = 0; k < EXTRA; k++) begin : g_stage
            always_ff @(posedge clk or negedge rst_n) begin
               if (!rst_n) begin
                  dly_r[k] <= '0;
               end else if (clr) begin
                  dly_r[k] <= '0;
               end else begin
                  // index clamped so the head stage never names dly_r[-1]
                  dly_r[k] <= (k == 0) ? sync2_r : dly_r[(k == 0) ? 0 : k - 1];
               end
            end
         end
         assign late = dly_r[EXTRA-1];
      end else begin : g_direct
         assign late = sync2_r;
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bin_out <= '0;
      end else if (clr) begin
         bin_out <= '0;
      end else begin
         bin_out <= gray_to_bin(late);
      end
   end
endmodule : dcfsf_ptr_cross
`default_nettype wire

// ---- core/dcfsf_top.sv ----
// dual-clock fifo core with full, empty, half-full and almost flags
//
`timescale 1ns/1ps
`default_nettype none
module dcfsf_top #(
   parameter int DEPTH = dcfsf_pkg::DEPTH_WORDS,
   parameter int WIDTH = dcfsf_pkg::DATA_WIDTH,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             CLK,
   input  wire logic             RST_N,
   input  wire logic             WCLK,
   input  wire logic             RCLK,
   input  wire logic             WRITE_EN_N,
   input  wire logic             READ_EN_N,
   input  wire logic [WIDTH-1:0] DATA_IN,
   input  wire logic             MASTER_RESET_N,
   input  wire logic             PARTIAL_RESET_N,
   input  wire logic             RETRANSMIT_N,
   input  wire logic             FALL_THROUGH_MODE,
   input  wire logic [AW-1:0]    EMPTY_OFFSET,
   input  wire logic [AW-1:0]    FULL_OFFSET,
   output logic      [WIDTH-1:0] DATA_OUT,
   output logic                  MEM_FULL_N,
   output logic                  INPUT_READY_N,
   output logic                  MEM_EMPTY_N,
   output logic                  OUTPUT_READY_N,
   output logic                  ALMOST_FULL_N,
   output logic                  ALMOST_EMPTY_N,
   output logic                  HALF_FULL_N
);
   localparam int PW = AW + 1;
   localparam int CW = dcfsf_pkg::PIN_CTL_W;
   localparam int SW = CW + WIDTH + 2 * AW;
   localparam logic [AW:0] DEPTH_P = PW'(DEPTH);
   localparam logic [AW:0] HALF_P  = PW'(DEPTH / 2);
   localparam logic [3:0]  RT_INIT = 4'(dcfsf_pkg::RT_CYC - 1);

   // pin sampling
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] pin_s1_r;
   logic [SW-1:0] pin_s2_r;
   logic [CW-1:0] ctl_d_r;
   logic [CW-1:0] ctl;

   assign pin_raw = {FULL_OFFSET, EMPTY_OFFSET, DATA_IN, FALL_THROUGH_MODE, RETRANSMIT_N,
                     PARTIAL_RESET_N, MASTER_RESET_N, READ_EN_N, WRITE_EN_N, RCLK, WCLK};

   // link clocks run far below CLK, so edges are found by oversampling
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         ctl_d_r  <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         ctl_d_r  <= pin_s2_r[CW-1:0];
      end
   end

   logic             wedge;
   logic             redge;
   logic             wen;
   logic             ren;
   logic             clr;
   logic             fall_through_mode;
   logic             rt_start;
   logic [WIDTH-1:0] din;
   logic [AW-1:0]    e_off;
   logic [AW-1:0]    f_off;

   assign ctl      = pin_s2_r[CW-1:0];
   assign wedge    = ctl[dcfsf_pkg::PIN_WCLK] & ~ctl_d_r[dcfsf_pkg::PIN_WCLK];
   assign redge    = ctl[dcfsf_pkg::PIN_RCLK] & ~ctl_d_r[dcfsf_pkg::PIN_RCLK];
   assign wen      = ~ctl[dcfsf_pkg::PIN_WEN_N];
   assign ren      = ~ctl[dcfsf_pkg::PIN_REN_N];
   // held one extra cycle so the edge detectors are primed before any transfer
   assign clr      = ~ctl[dcfsf_pkg::PIN_MRS_N] | ~ctl[dcfsf_pkg::PIN_PRS_N]
                   | ~ctl_d_r[dcfsf_pkg::PIN_MRS_N] | ~ctl_d_r[dcfsf_pkg::PIN_PRS_N];
   assign fall_through_mode     = ctl[dcfsf_pkg::PIN_FALL_THROUGH_MODE];
   assign rt_start = ~ctl[dcfsf_pkg::PIN_RT_N] & ctl_d_r[dcfsf_pkg::PIN_RT_N];
   assign din      = pin_s2_r[CW +: WIDTH];
   assign e_off    = pin_s2_r[CW + WIDTH +: AW];
   assign f_off    = pin_s2_r[CW + WIDTH + AW +: AW];

   // flag and pointer state
   logic [AW:0]      wptr_r, wptr_nxt;
   logic [AW:0]      rptr_r, rptr_nxt;
   logic             full_n_r, full_n_nxt;
   logic             ir_n_r, ir_n_nxt;
   logic             empty_n_r, empty_n_nxt;
   logic             or_n_r, or_n_nxt;
   logic             af_n_r, af_n_nxt;
   logic             ae_n_r, ae_n_nxt;
   logic             hf_n_r, hf_n_nxt;
   logic             ov_r, ov_nxt;
   logic             ne_r, ne_nxt;
   logic             rt_busy_r, rt_busy_nxt;
   logic [3:0]       rt_cnt_r, rt_cnt_nxt;
   logic [WIDTH-1:0] data_r, data_nxt;
   logic [WIDTH-1:0] mem [DEPTH];

   logic [AW:0] rptr_wr;
   logic [AW:0] wptr_rd;

   // write pointer reaches the read side after the fixed first-word latency
   dcfsf_ptr_cross #(.PW(PW), .EXTRA(dcfsf_pkg::FWL_EXTRA)) u_wptr_cross (
      .clk     (CLK),
      .rst_n   (RST_N),
      .clr     (clr),
      .bin_in  (wptr_r),
      .bin_out (wptr_rd)
   );

   dcfsf_ptr_cross #(.PW(PW), .EXTRA(0)) u_rptr_cross (
      .clk     (CLK),
      .rst_n   (RST_N),
      .clr     (clr),
      .bin_in  (rptr_r),
      .bin_out (rptr_wr)
   );

   logic        wr_ok;
   logic [AW:0] wcnt_n;
   logic [AW:0] rcnt_n;
   logic        avail;
   logic        avail_n;
   logic        rd_std;
   logic        load;
   logic        hf_set;
   logic [AW:0] hf_wcnt;
   logic [AW:0] hf_rcnt;
   logic [AW:0] ae_total;
   logic [AW:0] ae_lim;

   always_comb begin
      wptr_nxt    = wptr_r;
      rptr_nxt    = rptr_r;
      full_n_nxt  = full_n_r;
      ir_n_nxt    = ir_n_r;
      empty_n_nxt = empty_n_r;
      or_n_nxt    = or_n_r;
      af_n_nxt    = af_n_r;
      ae_n_nxt    = ae_n_r;
      hf_n_nxt    = hf_n_r;
      ov_nxt      = ov_r;
      ne_nxt      = ne_r;
      rt_busy_nxt = rt_busy_r;
      rt_cnt_nxt  = rt_cnt_r;
      data_nxt    = data_r;

      // write side: full means memory holds DEPTH words; in fall-through
      // the output register word is extra, giving DEPTH+1 writes
      wr_ok    = wedge & wen & full_n_r;
      wptr_nxt = wptr_r + {{AW{1'b0}}, wr_ok};
      wcnt_n   = wptr_nxt - rptr_wr;
      // half-full is asynchronous anyway, so it compares the live pointers:
      // a stale crossed pointer would let an idle read edge release it
      hf_wcnt  = wptr_nxt - rptr_r;
      hf_set   = wr_ok & (hf_wcnt > HALF_P);
      if (wedge) begin
         full_n_nxt = ~(wcnt_n == DEPTH_P);
         ir_n_nxt   = (wcnt_n == DEPTH_P);
         af_n_nxt   = ~(wcnt_n >= DEPTH_P - {1'b0, f_off});
      end

      // read side
      avail  = (wptr_rd != rptr_r) & ~rt_busy_r;
      rd_std = redge & ~fall_through_mode & ren & empty_n_r & avail;
      // a word must be seen on one read edge before it loads on the next
      load   = redge & fall_through_mode & ne_r & avail & (~ov_r | ren);
      rptr_nxt = rptr_r + {{AW{1'b0}}, (rd_std | load)};
      if (rd_std | load) begin
         data_nxt = mem[rptr_r[AW-1:0]];
      end
      if (load) begin
         ov_nxt = 1'b1;
      end else if (redge & fall_through_mode & ren & ov_r) begin
         ov_nxt = 1'b0;
      end
      avail_n  = (wptr_rd != rptr_nxt) & ~rt_busy_r;
      rcnt_n   = wptr_rd - rptr_nxt;
      hf_rcnt  = wptr_r - rptr_nxt;
      ae_total = rcnt_n + {{AW{1'b0}}, (fall_through_mode & ov_nxt)};
      ae_lim   = {1'b0, e_off} + {{AW{1'b0}}, fall_through_mode};
      if (redge) begin
         ne_nxt      = avail_n;
         empty_n_nxt = avail_n;
         or_n_nxt    = ~ov_nxt;
         ae_n_nxt    = ~(ae_total <= ae_lim);
      end

      // written by both clock sides; a write edge wins a collision
      if (hf_set) begin
         hf_n_nxt = 1'b0;
      end else if (redge & (hf_rcnt <= HALF_P)) begin
         hf_n_nxt = 1'b1;
      end

      // retransmit rewinds to the first word; flags hold off for the setup time
      if (rt_busy_r) begin
         if (rt_cnt_r == 4'h0) begin
            rt_busy_nxt = 1'b0;
         end else begin
            rt_cnt_nxt = rt_cnt_r - 4'h1;
         end
      end else if (rt_start) begin
         rt_busy_nxt = 1'b1;
         rt_cnt_nxt  = RT_INIT;
         rptr_nxt    = '0;
         ne_nxt      = 1'b0;
         ov_nxt      = 1'b0;
         empty_n_nxt = 1'b0;
         or_n_nxt    = 1'b1;
      end

      if (clr) begin
         wptr_nxt    = '0;
         rptr_nxt    = '0;
         full_n_nxt  = dcfsf_pkg::FULL_N_RST;
         ir_n_nxt    = dcfsf_pkg::IR_N_RST;
         empty_n_nxt = dcfsf_pkg::EMPTY_N_RST;
         or_n_nxt    = dcfsf_pkg::OR_N_RST;
         af_n_nxt    = dcfsf_pkg::AF_N_RST;
         ae_n_nxt    = dcfsf_pkg::AE_N_RST;
         hf_n_nxt    = dcfsf_pkg::HF_N_RST;
         ov_nxt      = 1'b0;
         ne_nxt      = 1'b0;
         rt_busy_nxt = 1'b0;
         rt_cnt_nxt  = 4'h0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wptr_r    <= '0;
         rptr_r    <= '0;
         full_n_r  <= dcfsf_pkg::FULL_N_RST;
         ir_n_r    <= dcfsf_pkg::IR_N_RST;
         empty_n_r <= dcfsf_pkg::EMPTY_N_RST;
         or_n_r    <= dcfsf_pkg::OR_N_RST;
         af_n_r    <= dcfsf_pkg::AF_N_RST;
         ae_n_r    <= dcfsf_pkg::AE_N_RST;
         hf_n_r    <= dcfsf_pkg::HF_N_RST;
         ov_r      <= 1'b0;
         ne_r      <= 1'b0;
         rt_busy_r <= 1'b0;
         rt_cnt_r  <= 4'h0;
         data_r    <= '0;
      end else begin
         wptr_r    <= wptr_nxt;
         rptr_r    <= rptr_nxt;
         full_n_r  <= full_n_nxt;
         ir_n_r    <= ir_n_nxt;
         empty_n_r <= empty_n_nxt;
         or_n_r    <= or_n_nxt;
         af_n_r    <= af_n_nxt;
         ae_n_r    <= ae_n_nxt;
         hf_n_r    <= hf_n_nxt;
         ov_r      <= ov_nxt;
         ne_r      <= ne_nxt;
         rt_busy_r <= rt_busy_nxt;
         rt_cnt_r  <= rt_cnt_nxt;
         data_r    <= data_nxt;
      end
   end

   // storage has no reset; contents kept across partial reset by design
   always_ff @(posedge CLK) begin
      if (wr_ok & ~clr) begin
         mem[wptr_r[AW-1:0]] <= din;
      end
   end

   assign DATA_OUT       = data_r;
   assign MEM_FULL_N     = full_n_r;
   assign INPUT_READY_N  = ir_n_r;
   assign MEM_EMPTY_N    = empty_n_r;
   assign OUTPUT_READY_N = or_n_r;
   assign ALMOST_FULL_N  = af_n_r;
   assign ALMOST_EMPTY_N = ae_n_r;
   assign HALF_FULL_N    = hf_n_r;

   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   logic [AW:0] wcnt_now;
   assign wcnt_now = wptr_r - rptr_wr;

   a_hf_write_low: assert property (hf_set && !clr |=> !HALF_FULL_N)
      else $error("half-full not set low by filling write edge");
   a_hf_read_high: assert property (redge && !hf_set && !clr && hf_rcnt <= HALF_P
                                    |=> HALF_FULL_N)
      else $error("half-full not released by read edge");
   a_hf_count: assert property ($fell(HALF_FULL_N) |-> wptr_r - $past(rptr_r) > HALF_P)
      else $error("half-full low with memory count at or below half");
   a_full_count: assert property ($fell(MEM_FULL_N) |-> wptr_r - $past(rptr_wr) == DEPTH_P)
      else $error("full flag low while memory not full");
   a_no_overflow: assert property (wcnt_now <= DEPTH_P)
      else $error("write side count exceeds depth");
   a_empty_on_redge: assert property ($rose(MEM_EMPTY_N) |-> $past(redge)
                                      && !$past(rt_busy_r))
      else $error("empty flag cleared off a read edge or during retransmit");
   a_or_two_edges: assert property ($fell(OUTPUT_READY_N) |-> $past(ne_r)
                                    && $past(redge))
      else $error("output-ready asserted without a prior read edge seeing data");
   a_ae_read_edge: assert property ($rose(ALMOST_EMPTY_N) |-> $past(redge))
      else $error("almost-empty released off a read edge");
   a_af_write_edge: assert property ($changed(ALMOST_FULL_N) |-> $past(wedge)
                                     || $past(clr))
      else $error("almost-full changed off a write edge");
   a_rt_hold: assert property (rt_start && !rt_busy_r && !clr
                               |=> (rt_busy_r && !MEM_EMPTY_N && OUTPUT_READY_N)[*5])
      else $error("retransmit setup time not held");
   a_fall_through_mode_idle_read: assert property (fall_through_mode && !ne_r && !rt_start && !clr
                                      |=> $stable(DATA_OUT))
      else $error("output changed while memory seen empty");

   c_retransmit: cover property (rt_start && !rt_busy_r && !clr);
   c_full: cover property ($fell(MEM_FULL_N));
   c_fall_through: cover property ($fell(OUTPUT_READY_N));
   c_half_full: cover property ($fell(HALF_FULL_N) ##[1:1000] $rose(HALF_FULL_N));
endmodule : dcfsf_top
`default_nettype wire

// ---- verification/dcfsf_partner.sv ----
// writer and reader model on free-running link clocks
`timescale 1ns/1ps
`default_nettype none
module dcfsf_partner (
   input  wire logic                          clk,
   output logic                               wclk,
   output logic                               rclk,
   output logic                               wen_n,
   output logic                               ren_n,
   output logic [dcfsf_pkg::DATA_WIDTH-1:0]   din
);
   initial begin
      wclk = 1'b0;
      rclk = 1'b0;
      wen_n = 1'b1;
      ren_n = 1'b1;
      din = '0;
   end
   // fifo clocks run free at one period; the read side rises 37 ns after the write side
   always #62.5 wclk = ~wclk;
   always begin
      #37;
      forever #62.5 rclk = ~rclk;
   end
   // changes land mid-period so pins are stable well around each rise
   task automatic wr(input logic en, input logic [dcfsf_pkg::DATA_WIDTH-1:0] d);
      @(negedge wclk);
      @(posedge clk);
      wen_n <= ~en;
      din   <= en ? d : ~din; // released bus never keeps the stale word
   endtask : wr
   task automatic rd(input logic en);
      @(negedge rclk);
      @(posedge clk);
      ren_n <= ~en;
   endtask : rd
endmodule : dcfsf_partner
`default_nettype wire

// ---- verification/dcfsf_top_tb.sv ----
// self-checking bench for the dual-clock fifo flags
`timescale 1ns/1ps
`default_nettype none
module dcfsf_top_tb;
   localparam int D = 16;
   localparam int W = dcfsf_pkg::DATA_WIDTH;
   logic          clk;
   logic          rst_n;
   logic          mrs_n;
   logic          prs_n;
   logic          rt_n;
   logic          fall_through_mode;
   wire logic     wclk;
   wire logic     rclk;
   wire logic     wen_n;
   wire logic     ren_n;
   wire logic [W-1:0] din;
   logic [W-1:0]  dout;
   logic          full_n, ir_n, empty_n, or_n, af_n, ae_n, hf_n;
   logic [6:0]    flags;
   int            fail_count, total_checks, cyc;
   logic [W-1:0]  exp_q[$];
   logic [W-1:0]  hist[$];
   assign flags = {hf_n, ae_n, af_n, or_n, empty_n, ir_n, full_n};
   dcfsf_partner model_u (.clk(clk), .wclk(wclk), .rclk(rclk), .wen_n(wen_n),
      .ren_n(ren_n), .din(din));
   dcfsf_top #(.DEPTH(D)) dut_u (.CLK(clk), .RST_N(rst_n), .WCLK(wclk), .RCLK(rclk),
      .WRITE_EN_N(wen_n), .READ_EN_N(ren_n), .DATA_IN(din), .MASTER_RESET_N(mrs_n),
      .PARTIAL_RESET_N(prs_n), .RETRANSMIT_N(rt_n), .FALL_THROUGH_MODE(fall_through_mode),
      .EMPTY_OFFSET(4'h2), .FULL_OFFSET(4'h3), .DATA_OUT(dout), .MEM_FULL_N(full_n),
      .INPUT_READY_N(ir_n), .MEM_EMPTY_N(empty_n), .OUTPUT_READY_N(or_n),
      .ALMOST_FULL_N(af_n), .ALMOST_EMPTY_N(ae_n), .HALF_FULL_N(hf_n));
   always #5 clk = ~clk;
   task automatic check(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   // flag index: 0 full, 1 ir, 2 empty, 3 or, 4 af, 5 ae, 6 hf
   task automatic wait_flag(input string name, input int idx, input logic v, input int lim);
      int n;
      n = 0;
      while (flags[idx] !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      check(name, W'(flags[idx]), W'(v));
   endtask : wait_flag
   task automatic put(input int n);
      logic [W-1:0] d;
      d = '0;
      repeat (n) begin
         d = W'($urandom);
         model_u.wr(1'b1, d);
         exp_q.push_back(d);
         hist.push_back(d);
      end
      model_u.wr(1'b0, d);
   endtask : put
   task automatic get(input int n);
      repeat (n) model_u.rd(1'b1);
      model_u.rd(1'b0);
   endtask : get
   task automatic fifo_reset(input logic mode, input logic part);
      @(posedge clk);
      mrs_n <= part;
      prs_n <= ~part;
      fall_through_mode  <= mode;
      repeat (20) @(posedge clk);
      check("rstflags", W'(flags), W'(7'b1011001));
      mrs_n <= 1'b1;
      prs_n <= 1'b1;
      exp_q.delete();
      hist.delete();
      repeat (20) @(posedge clk);
   endtask : fifo_reset
   // setup flags are checked inside the busy window, then the replay is expected
   task automatic retransmit();
      @(posedge clk);
      rt_n <= 1'b0;
      repeat (8) @(posedge clk);
      check("rtsetup", W'(flags[3:2]), W'(2'b10));
      repeat (12) @(posedge clk);
      rt_n <= 1'b1;
      exp_q = hist;
   endtask : retransmit
   // a word shows 3 clocks after a read rise and is checked at 8; both modes judged here
   always @(posedge rclk) begin
      logic ren, emp, orp;
      ren = ~ren_n;
      emp = empty_n;
      orp = or_n;
      repeat (8) @(posedge clk);
      if (fall_through_mode ? (!or_n && (orp || ren)) : (ren && emp)) begin
         check("dout", dout, exp_q.size() > 0 ? exp_q.pop_front() : ~dout);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      mrs_n = 1'b1;
      prs_n = 1'b1;
      rt_n = 1'b1;
      fall_through_mode = 1'b0;
      fail_count = 0;
      total_checks = 0;
      cyc = 0;
      void'($urandom(32'h462d));
      repeat (4) @(posedge clk);
      check("rst", dout, '0);
      rst_n <= 1'b1;
      fifo_reset(1'b0, 1'b0);
      put(1);
      wait_flag("empty", 2, 1'b1, 30);
      check("ae", W'(ae_n), W'(1'b0));
      put(D / 2 - 1);
      check("hf", W'(hf_n), W'(1'b1));
      put(1);
      check("hf", W'(hf_n), W'(1'b0));
      wait_flag("ae", 5, 1'b1, 30);
      put(4);
      check("af", W'(af_n), W'(1'b0));
      put(3);
      check("full", W'(full_n), W'(1'b0));
      get(1);
      wait_flag("full", 0, 1'b1, 34);
      check("af", W'(af_n), W'(1'b0));
      get(3);
      wait_flag("af", 4, 1'b1, 34);
      check("hf", W'(hf_n), W'(1'b0));
      get(4);
      wait_flag("hf", 6, 1'b1, 30);
      get(9);
      wait_flag("empty", 2, 1'b0, 30);
      fifo_reset(1'b0, 1'b1);
      put(3);
      wait_flag("empty", 2, 1'b1, 30);
      get(2);
      retransmit();
      wait_flag("empty", 2, 1'b1, 40);
      get(3);
      fifo_reset(1'b1, 1'b0);
      get(1);
      put(1);
      wait_flag("or", 3, 1'b0, 45);
      put(8);
      check("hf", W'(hf_n), W'(1'b1));
      put(1);
      check("hf", W'(hf_n), W'(1'b0));
      put(6);
      check("ir", W'(ir_n), W'(1'b0));
      put(1);
      check("ir", W'(ir_n), W'(1'b1));
      get(1);
      wait_flag("ir", 1, 1'b0, 34);
      get(17);
      wait_flag("or", 3, 1'b1, 30);
      fifo_reset(1'b1, 1'b1);
      put(3);
      wait_flag("or", 3, 1'b0, 45);
      retransmit();
      wait_flag("or", 3, 1'b0, 40);
      get(3);
      repeat (20) @(posedge clk);
      check("left", W'(exp_q.size()), '0);
      final_report();
   end
endmodule : dcfsf_top_tb
`default_nettype wire
